/* src/fmrs_seq.sv */
// Operation
// - start bit after waveform select runs waveform
// - hop equals deviation word shifted by shift
// - timer mode 11: hop interval step_timer_div_a times step_timer_div_b
// - triangle sweeps up then down, double period
// - dual-rate bit enables two independent ramp settings
// - deviation select bit picks target deviation set
// - step select bit picks target step count
// - rewriting idle set never disturbs running ramp
// - fsk bit adds second deviation as offset
// - fsk mode ramps set zero, offsets set one
// - keying pin level applies or removes offset
// - delayed start holds off first hop
// - delay clock clear: delay word reference periods
// - delay clock set: word times step_timer_div_a periods
// - gap bit inserts delay between ramp bursts
// - fast lock during first gap delay period
// - dual rate and gap delay work together
// - twenty-bit step count sets hops per segment
// - sawtooth restores base on timeout after last
// - continuous triangle alternates direction until stopped
//
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "fmrs_defs.svh"

module fmrs_seq (
    input  wire logic            clk_sys,         // reference clock
    input  wire logic            srst,            // sync reset, active high
    input  wire logic [5:0]      avs_address,     // byte address
    input  wire logic            avs_read,        // read request
    input  wire logic            avs_write,       // write request
    input  wire logic [31:0]     avs_writedata,   // write data
    input  wire logic [3:0]      avs_byteenable,  // byte lanes
    output logic      [31:0]     avs_readdata,    // read data
    output logic                 avs_waitrequest, // stall
    input  wire logic            freqKeyPin,      // frequency_keying pin
    output logic      [36:0]     divValue,        // divider int and fraction
    output logic                 fastLock,        // wide loop request
    output logic                 rampActive,      // sweep in progress
    output fmrs_pkg::fmrs_state_t rampState       // sequencer state
);
    import fmrs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // bus slave

    logic        waitReq_q;
    logic        busWr;
    logic        busAcc;
    logic [3:0]  wrIdx;
    logic [31:0] wMask;
    logic [31:0] curWord;
    logic [31:0] merged;
    logic [31:0] regs_q [0:7];

    assign wrIdx  = avs_address[5:2];
    assign busAcc = (avs_read || avs_write) && waitReq_q;
    assign busWr  = avs_write && !waitReq_q;
    assign wMask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign curWord = (wrIdx < `FMRS_NUM_CFG) ? regs_q[wrIdx[2:0]]
                                              : 32'h0;
    assign merged = (curWord & ~wMask) | (avs_writedata & wMask);

    // one wait cycle: the request is seen, then released with data
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            waitReq_q <= 1'b1;
        end else if (busAcc) begin
            waitReq_q <= 1'b0;
        end else begin
            waitReq_q <= 1'b1;
        end
    end

    assign avs_waitrequest = waitReq_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < 8; i++) begin
                regs_q[i] <= `FMRS_REG_RST;
            end
        end else if (busWr && (wrIdx < `FMRS_NUM_CFG)) begin
            regs_q[wrIdx[2:0]] <= merged;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field decode

    logic [31:0] r0Now;
    logic [36:0] baseDiv;
    logic [11:0] step_timer_div_a;
    logic [11:0] step_timer_div_b;
    logic [1:0]  tmode;
    logic [1:0]  wave;
    logic        isTri;
    logic        isOnce;
    logic        dualEn;
    logic        fskEn;
    logic [11:0] dlyWord;
    logic        dlyStartEn;
    logic        dlyClkSel;
    logic        gapEn;
    logic        dlyFlEn;
    logic        startWr;
    logic        startBit;
    logic [23:0] hopLimit;
    logic [23:0] dlyLimit;
    logic [11:0] flUnit;
    logic        pairSets;

    assign startWr  = busWr && (wrIdx == `FMRS_IDX_FREQ);
    assign startBit = merged[`FMRS_START_BIT];
    // base taken from the word being written so a start sees it at once
    assign r0Now    = startWr ? merged : regs_q[0];
    assign baseDiv  = {r0Now[`FMRS_INT_MSB:`FMRS_INT_LSB],
                       r0Now[`FMRS_FRACH_MSB:`FMRS_FRACH_LSB],
                       regs_q[1][`FMRS_FRACL_MSB:`FMRS_FRACL_LSB]};

    assign step_timer_div_a       = regs_q[2][`FMRS_STEP_TIMER_DIV_A_MSB:`FMRS_STEP_TIMER_DIV_A_LSB];
    assign wave       = regs_q[3][`FMRS_WAVE_MSB:`FMRS_WAVE_LSB];
    assign isTri      = wave[`FMRS_WAVE_TRI];
    assign isOnce     = wave[`FMRS_WAVE_ONCE];
    assign step_timer_div_b       = regs_q[4][`FMRS_STEP_TIMER_DIV_B_MSB:`FMRS_STEP_TIMER_DIV_B_LSB];
    assign tmode      = regs_q[4][`FMRS_TMODE_MSB:`FMRS_TMODE_LSB];
    assign dualEn     = regs_q[5][`FMRS_DUAL_BIT];
    assign fskEn      = regs_q[5][`FMRS_FSK_BIT];
    assign dlyWord    = regs_q[7][`FMRS_DLYW_MSB:`FMRS_DLYW_LSB];
    assign dlyStartEn = regs_q[7][`FMRS_DLYST_BIT];
    assign dlyClkSel  = regs_q[7][`FMRS_DLYCK_BIT];
    assign gapEn      = regs_q[7][`FMRS_GAP_BIT];
    assign dlyFlEn    = regs_q[7][`FMRS_DLYFL_BIT];

    // ramp set one only drives ramp steps when fsk does not own it
    assign pairSets = dualEn && !fskEn;

    assign hopLimit = step_timer_div_a * step_timer_div_b;
    assign dlyLimit = dlyClkSel ? (dlyWord * step_timer_div_a)
                                : {12'h000, dlyWord};
    assign flUnit   = (dlyClkSel && (step_timer_div_a != 12'h000)) ? step_timer_div_a : 12'h001;

    ////////////////////////////////////////////////////////////////////////
    // two ramp settings, written through the select bit

    logic [15:0] devSet_q   [0:1];
    logic [3:0]  shiftSet_q [0:1];
    logic [19:0] stepSet_q  [0:1];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < 2; i++) begin
                devSet_q[i]   <= 16'h0000;
                shiftSet_q[i] <= 4'h0;
            end
        end else if (busWr && (wrIdx == `FMRS_IDX_DEV)) begin
            devSet_q[merged[`FMRS_SEL_BIT]] <=
                merged[`FMRS_DEV_MSB:`FMRS_DEV_LSB];
            shiftSet_q[merged[`FMRS_SEL_BIT]] <=
                merged[`FMRS_SHIFT_MSB:`FMRS_SHIFT_LSB];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < 2; i++) begin
                stepSet_q[i] <= 20'h00000;
            end
        end else if (busWr && (wrIdx == `FMRS_IDX_STEP)) begin
            stepSet_q[merged[`FMRS_SEL_BIT]] <=
                merged[`FMRS_STEPS_MSB:`FMRS_STEPS_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timers and keying pin

    fmrs_state_t state_q;
    logic        hopTick;
    logic        dlyTick;
    logic        keyed;
    logic        inDly;

    assign inDly = (state_q == ST_START_DLY) || (state_q == ST_GAP_DLY);

    fmrs_interval hopTimer (
        .clk_sys (clk_sys),
        .srst    (srst),
        .clear   (startWr),
        .run     ((state_q == ST_RAMP) &&
                  (tmode == `FMRS_TMODE_RAMP)),
        .limit   (hopLimit),
        .tick    (hopTick)
    );

    fmrs_interval dlyTimer (
        .clk_sys (clk_sys),
        .srst    (srst),
        .clear   (startWr),
        .run     (inDly),
        .limit   (dlyLimit),
        .tick    (dlyTick)
    );

    fmrs_pin_sync keySync (
        .clk_sys (clk_sys),
        .srst    (srst),
        .pinIn   (freqKeyPin),
        .level   (keyed)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    logic               dirUp_q;
    logic               seg_q;
    logic [19:0]        stepCnt_q;
    logic [15:0]        curDev_q;
    logic [3:0]         curShift_q;
    logic [19:0]        curSteps_q;
    logic [36:0]        acc_q;
    logic signed [36:0] devExt;
    logic signed [36:0] stepAmt;
    logic               segDone;
    logic               seg1Idx;

    assign devExt  = {{21{curDev_q[15]}}, curDev_q};
    assign stepAmt = devExt <<< curShift_q;
    assign segDone = (stepCnt_q == curSteps_q);
    assign seg1Idx = pairSets;

    // settings are latched per segment, so the idle set may be rewritten
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q    <= ST_IDLE;
            dirUp_q    <= 1'b1;
            seg_q      <= 1'b0;
            stepCnt_q  <= 20'h00000;
            curDev_q   <= 16'h0000;
            curShift_q <= 4'h0;
            curSteps_q <= 20'h00000;
            acc_q      <= 37'h0;
        end else if (startWr) begin
            acc_q     <= baseDiv;
            stepCnt_q <= 20'h00000;
            dirUp_q   <= 1'b1;
            seg_q     <= 1'b0;
            if (startBit) begin
                curDev_q   <= devSet_q[0];
                curShift_q <= shiftSet_q[0];
                curSteps_q <= stepSet_q[0];
                if (dlyStartEn && (dlyLimit != 24'h0)) begin
                    state_q <= ST_START_DLY;
                end else begin
                    state_q <= ST_RAMP;
                end
            end else begin
                state_q <= ST_IDLE;
            end
        end else begin
            case (state_q)
                ST_START_DLY, ST_GAP_DLY: begin
                    if (dlyTick) begin
                        state_q <= ST_RAMP;
                    end
                end
                ST_RAMP: begin
                    if (hopTick && !segDone) begin
                        if (dirUp_q) begin
                            acc_q <= acc_q + stepAmt;
                        end else begin
                            acc_q <= acc_q - stepAmt;
                        end
                        stepCnt_q <= stepCnt_q + 20'h00001;
                    end else if (hopTick && isTri && dirUp_q) begin
                        dirUp_q    <= 1'b0;
                        seg_q      <= 1'b1;
                        stepCnt_q  <= 20'h00000;
                        curDev_q   <= devSet_q[seg1Idx];
                        curShift_q <= shiftSet_q[seg1Idx];
                        curSteps_q <= stepSet_q[seg1Idx];
                    end else if (hopTick && !isTri && pairSets &&
                                 !seg_q) begin
                        seg_q      <= 1'b1;
                        stepCnt_q  <= 20'h00000;
                        curDev_q   <= devSet_q[1];
                        curShift_q <= shiftSet_q[1];
                        curSteps_q <= stepSet_q[1];
                    end else if (hopTick) begin
                        // end of burst
                        if (!isTri) begin
                            acc_q <= baseDiv;
                        end
                        dirUp_q    <= 1'b1;
                        seg_q      <= 1'b0;
                        stepCnt_q  <= 20'h00000;
                        curDev_q   <= devSet_q[0];
                        curShift_q <= shiftSet_q[0];
                        curSteps_q <= stepSet_q[0];
                        if (isOnce) begin
                            state_q <= ST_DONE;
                        end else if (gapEn && (dlyLimit != 24'h0)) begin
                            state_q <= ST_GAP_DLY;
                        end
                    end
                end
                ST_IDLE, ST_DONE: begin
                    state_q <= state_q;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fast lock over the first delay-clock period of a gap

    logic [11:0] flCnt_q;
    logic        fastLock_q;
    logic        gapEnter;

    assign gapEnter = (state_q == ST_RAMP) && hopTick && segDone &&
                      !(isTri && dirUp_q) &&
                      !(!isTri && pairSets && !seg_q) &&
                      !isOnce && gapEn && (dlyLimit != 24'h0) && !startWr;

    always_ff @(posedge clk_sys) begin
        if (srst || startWr) begin
            fastLock_q <= 1'b0;
            flCnt_q    <= 12'h000;
        end else if (gapEnter) begin
            fastLock_q <= dlyFlEn;
            flCnt_q    <= 12'h000;
        end else if (fastLock_q) begin
            if ((flCnt_q + 12'h001 >= flUnit) || (state_q != ST_GAP_DLY)) begin
                fastLock_q <= 1'b0;
            end
            flCnt_q <= flCnt_q + 12'h001;
        end
    end

    assign fastLock = fastLock_q;

    ////////////////////////////////////////////////////////////////////////
    // divider output with keyed offset

    logic signed [36:0] fskOfs;
    logic        [36:0] divValue_q;

    // fsk offset always comes from the second deviation set
    assign fskOfs = {{21{devSet_q[1][15]}}, devSet_q[1]} <<< shiftSet_q[1];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            divValue_q <= 37'h0;
        end else if (fskEn && keyed) begin
            divValue_q <= acc_q + fskOfs;
        end else begin
            divValue_q <= acc_q;
        end
    end

    assign divValue = divValue_q;

    logic rampActive_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rampActive_q <= 1'b0;
        end else begin
            rampActive_q <= inDly || (state_q == ST_RAMP);
        end
    end

    assign rampActive = rampActive_q;
    assign rampState  = state_q;

    ////////////////////////////////////////////////////////////////////////
    // read path

    logic [31:0] rdData_q;
    logic [31:0] statusWord;

    assign statusWord = {stepCnt_q, 5'h00, keyed, fastLock_q, dirUp_q,
                         seg_q, 3'(state_q)};

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdData_q <= 32'h0;
        end else if (busAcc && avs_read) begin
            if (wrIdx < `FMRS_NUM_CFG) begin
                rdData_q <= regs_q[wrIdx[2:0]];
            end else if (wrIdx == `FMRS_IDX_STAT) begin
                rdData_q <= statusWord;
            end else if (wrIdx == `FMRS_IDX_DIVLO) begin
                rdData_q <= divValue_q[31:0];
            end else if (wrIdx == `FMRS_IDX_DIVHI) begin
                rdData_q <= {27'h0, divValue_q[36:32]};
            end else begin
                rdData_q <= 32'h0;
            end
        end
    end

    assign avs_readdata = rdData_q;

endmodule : fmrs_seq

`default_nettype wire

/* src/fmrs_defs.svh */
`ifndef FMRS_DEFS_SVH
`define FMRS_DEFS_SVH

// word indices; byte address is four times the index
`define FMRS_IDX_FREQ   4'h0
`define FMRS_IDX_FRACL  4'h1
`define FMRS_IDX_RDIV   4'h2
`define FMRS_IDX_FUNC   4'h3
`define FMRS_IDX_CLK    4'h4
`define FMRS_IDX_DEV    4'h5
`define FMRS_IDX_STEP   4'h6
`define FMRS_IDX_DELAY  4'h7
`define FMRS_IDX_STAT   4'h8
`define FMRS_IDX_DIVLO  4'h9
`define FMRS_IDX_DIVHI  4'ha
`define FMRS_NUM_CFG    4'h8

`define FMRS_REG_RST    32'h0000_0000

// frequency register
`define FMRS_START_BIT  31
`define FMRS_INT_MSB    26
`define FMRS_INT_LSB    15
`define FMRS_FRACH_MSB  14
`define FMRS_FRACH_LSB  3
// lsb fraction register
`define FMRS_FRACL_MSB  27
`define FMRS_FRACL_LSB  15
// divider and clock registers
`define FMRS_STEP_TIMER_DIV_A_MSB   14
`define FMRS_STEP_TIMER_DIV_A_LSB   3
`define FMRS_STEP_TIMER_DIV_B_MSB   18
`define FMRS_STEP_TIMER_DIV_B_LSB   7
`define FMRS_TMODE_MSB  20
`define FMRS_TMODE_LSB  19
`define FMRS_TMODE_RAMP 2'h3
// function register
`define FMRS_WAVE_MSB   11
`define FMRS_WAVE_LSB   10
`define FMRS_WAVE_TRI   0
`define FMRS_WAVE_ONCE  1
// deviation register
`define FMRS_DEV_MSB    18
`define FMRS_DEV_LSB    3
`define FMRS_SHIFT_MSB  22
`define FMRS_SHIFT_LSB  19
`define FMRS_SEL_BIT    23
`define FMRS_DUAL_BIT   24
`define FMRS_FSK_BIT    25
// step register
`define FMRS_STEPS_MSB  22
`define FMRS_STEPS_LSB  3
// delay register
`define FMRS_DLYW_MSB   14
`define FMRS_DLYW_LSB   3
`define FMRS_DLYST_BIT  15
`define FMRS_DLYCK_BIT  16
`define FMRS_GAP_BIT    17
`define FMRS_DLYFL_BIT  18

`endif

/* src/fmrs_pkg.sv */
package fmrs_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START_DLY,
        ST_RAMP,
        ST_GAP_DLY,
        ST_DONE
    } fmrs_state_t;

endpackage : fmrs_pkg

/* src/fmrs_pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module fmrs_pin_sync (
    input  wire logic clk_sys, // system clock
    input  wire logic srst,    // sync reset, active high
    input  wire logic pinIn,   // asynchronous pin
    output logic      level    // filtered level
);

    logic [2:0] sh_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sh_q <= 3'h0;
        end else begin
            sh_q <= {sh_q[1:0], pinIn};
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            level <= 1'b0;
        end else if (sh_q[1] == sh_q[2]) begin
            level <= sh_q[2];
        end
    end

endmodule : fmrs_pin_sync

`default_nettype wire

/* src/fmrs_interval.sv */
`timescale 1ns/1ns
`default_nettype none

module fmrs_interval (
    input  wire logic        clk_sys, // system clock
    input  wire logic        srst,    // sync reset, active high
    input  wire logic        clear,   // restart count
    input  wire logic        run,     // count enable
    input  wire logic [23:0] limit,   // cycles per tick, 0 = never
    output logic             tick     // one-cycle pulse per interval
);

    logic [23:0] cnt_q;

    assign tick = run && (limit != 24'h0) && (cnt_q == limit - 24'h1);

    always_ff @(posedge clk_sys) begin
        if (srst || clear || !run || tick) begin
            cnt_q <= 24'h0;
        end else begin
            cnt_q <= cnt_q + 24'h1;
        end
    end

endmodule : fmrs_interval

`default_nettype wire

/* tb/fmrs_seq_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module fmrs_seq_checker (
    input wire logic                  clk_sys,         // clock
    input wire logic                  srst,            // reset
    input wire logic [5:0]            avs_address,     // address
    input wire logic                  avs_read,        // read
    input wire logic                  avs_write,       // write
    input wire logic [31:0]           avs_writedata,   // write data
    input wire logic [3:0]            avs_byteenable,  // lanes
    input wire logic [31:0]           avs_readdata,    // read data
    input wire logic                  avs_waitrequest, // stall
    input wire logic                  freqKeyPin,      // key pin
    input wire logic [36:0]           divValue,        // divider
    input wire logic                  fastLock,        // wide loop
    input wire logic                  rampActive,      // busy
    input wire fmrs_pkg::fmrs_state_t rampState        // state
);
    import fmrs_pkg::*;
    logic go;
    // frequency word write completing at this edge
    assign go = avs_write && !avs_waitrequest && avs_address[5:2] == 4'h0
                && avs_byteenable[3];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest) else $error("late answer");
    wait_cause_a: assert property (!avs_waitrequest
        |-> $past(avs_read || avs_write)) else $error("spurious answer");
    refused_read_a: assert property (avs_read && !avs_waitrequest
        && avs_address[5:2] > 4'ha |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    start_run_a: assert property (
        go && avs_writedata[31] |=> rampState inside {ST_START_DLY, ST_RAMP})
        else $error("start ignored");
    stop_hold_a: assert property (
        go && !avs_writedata[31] |=> rampState == ST_IDLE ##1 !rampActive)
        else $error("stop ignored");
    delay_hold_a: assert property (
        rampState inside {ST_START_DLY, ST_GAP_DLY} ##1
        rampState inside {ST_START_DLY, ST_GAP_DLY} |=> $stable(divValue))
        else $error("divider moved in delay");
    fast_gap_a: assert property (fastLock |-> rampState == ST_GAP_DLY
        || $past(rampState) == ST_GAP_DLY) else $error("fast lock outside gap");
    active_flag_a: assert property ($past(rampState) == rampState
        |-> rampActive == (rampState inside {ST_START_DLY, ST_RAMP, ST_GAP_DLY}))
        else $error("active flag wrong");
    done_stay_a: assert property (rampState == ST_DONE && !go
        |=> rampState == ST_DONE) else $error("left done");
    cover property (rampState == ST_GAP_DLY);
    cover property (rampState == ST_DONE);
    cover property (fastLock);
endmodule : fmrs_seq_checker
bind fmrs_seq fmrs_seq_checker chk (.clk_sys, .srst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .freqKeyPin, .divValue, .fastLock, .rampActive,
    .rampState);
`default_nettype wire

/* tb/fmrs_host.sv */
`timescale 1ns/1ns
`default_nettype none
module fmrs_host (
    input  wire logic        clk_sys,         // clock
    input  wire logic        avs_waitrequest, // stall
    input  wire logic [31:0] avs_readdata,    // read data
    output var logic  [5:0]  avs_address,     // address
    output var logic         avs_read,        // read
    output var logic         avs_write,       // write
    output var logic  [31:0] avs_writedata,   // write data
    output var logic  [3:0]  avs_byteenable   // lanes
);
    initial begin
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
    end
    ////////////////////////////////////////////////////////////
    // an edge passes first so a release never meets the next raise
    task automatic xfer(input logic rd, input logic [3:0] idx,
                        input logic [31:0] wd, output logic [31:0] q);
        @(posedge clk_sys);
        avs_address <= {idx, 2'h0};
        avs_read <= rd;
        avs_write <= !rd;
        avs_writedata <= wd;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // released lines must not keep showing the old word
        avs_address <= ~avs_address;
        avs_writedata <= ~avs_writedata;
    endtask : xfer
endmodule : fmrs_host
`default_nettype wire

/* tb/fmrs_ramp_sequencer_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module fmrs_ramp_sequencer_tb;
    import fmrs_pkg::*;
    localparam logic [36:0] BASE = {12'h064, 12'h100, 13'h0};
    localparam logic [31:0] F0 = {5'h0, 12'h064, 12'h100, 3'h0};
    localparam logic [31:0] DEV0 = 32'h0010_0028;
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic        freqKeyPin = 1'b0;
    logic [5:0]  avs_address;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic [36:0] divValue, prev;
    logic        fastLock, rampActive;
    fmrs_state_t rampState;
    int          fail_count = 0;
    int          cmp_count = 0;
    int dl [4][6] = '{'{20, 40, 60, 0, 20, 40}, '{20, 40, 60, 40, 20, 0},
                      '{20, 40, 60, 0, -1, -1}, '{20, 40, 60, 40, 20, 0}};
    int gp [4][6] = '{'{0, 6, 6, 6, 6, 6}, '{0, 6, 6, 12, 6, 6},
                      '{0, 6, 6, 6, 0, 0}, '{0, 6, 6, 12, 6, 6}};

    always #5 clk_sys = ~clk_sys;
    fmrs_host host (.clk_sys, .avs_waitrequest, .avs_readdata, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable);
    fmrs_seq uut (.clk_sys, .srst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .freqKeyPin, .divValue, .fastLock, .rampActive, .rampState);
    ////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    task automatic cmpv(input logic [36:0] got, input logic [36:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmpv
    task automatic cmpn(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            fail_count++;
            $display("wrong value at %0t: %0d cycles not %0d", $time, got, exp);
        end
    endtask : cmpn
    task automatic wr(input logic [3:0] i, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(1'b0, i, d, q);
    endtask : wr
    task automatic rd(input logic [3:0] i, input logic [31:0] e);
        logic [31:0] q;
        host.xfer(1'b1, i, 32'h0, q);
        cmpv({5'h0, q}, {5'h0, e});
    endtask : rd
    // delay word first, frequency word with start bit last
    task automatic prog(input logic [31:0] dly, dev0, dev1, stp1,
                        input logic [11:0] step_timer_div_b, input logic [1:0] wave);
        wr(4'h7, dly);
        wr(4'h6, 32'h18);
        if (stp1 != 0) wr(4'h6, stp1);
        wr(4'h5, dev0);
        if (dev1 != 0) wr(4'h5, dev1);
        wr(4'h4, {11'h0, 2'h3, step_timer_div_b, 7'h0});
        wr(4'h3, {20'h0, wave, 10'h0});
        wr(4'h2, 32'h18);
        wr(4'h1, 32'h0);
        wr(4'h0, F0 | 32'h8000_0000);
    endtask : prog
    task automatic base();
        repeat (2) @(negedge clk_sys);
        cmpv(divValue, BASE);
        prev = divValue;
    endtask : base
    task automatic hop(input logic [36:0] exp, input int n);
        int c = 0;
        do begin
            @(negedge clk_sys);
            c++;
        end while (divValue === prev && c < 300);
        cmpv(divValue, exp);
        if (n != 0) cmpn(c, n);
        prev = divValue;
    endtask : hop
    task automatic span(input fmrs_state_t st, input int exp, input int fl);
        int c = 0;
        int f = 0;
        int w = 0;
        while (rampState !== st && w < 300) begin
            @(negedge clk_sys);
            w++;
        end
        while (rampState === st) begin
            if (fastLock === 1'b1) f++;
            c++;
            @(negedge clk_sys);
        end
        cmpn(c, exp);
        if (fl >= 0) cmpn(f, fl);
    endtask : span
    task automatic waitst(input fmrs_state_t st);
        int w = 0;
        while (rampState !== st && w < 50) begin
            @(negedge clk_sys);
            w++;
        end
        cmpv(37'(rampState), 37'(st));
    endtask : waitst
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        rd(4'h8, 32'h10);
        wr(4'h9, 32'hffff_ffff);
        rd(4'h9, 32'h0);
        rd(4'hb, 32'h0);
        for (int w = 0; w < 4; w++) begin
            prog(32'h0, DEV0, 32'h0, 32'h0, 12'h002, w[1:0]);
            base();
            for (int k = 0; k < 6; k++)
                if (dl[w][k] >= 0)
                    hop(BASE + 37'(dl[w][k]), gp[w][k]);
            if (w >= 2) waitst(ST_DONE);
        end
        // dual rate, delayed start and gap with fast lock
        prog(32'h0006_8020, 32'h0110_0028, 32'h0180_0018, 32'h0080_0008,
             12'h002, 2'h0);
        span(ST_START_DLY, 4, -1);
        base();
        hop(BASE + 37'h14, 0);
        wr(4'h5, 32'h0180_0010);
        hop(BASE + 37'h28, 0);
        hop(BASE + 37'h3c, 6);
        hop(BASE + 37'h3e, 12);
        span(ST_GAP_DLY, 4, 1);
        base();
        hop(BASE + 37'h14, 0);
        prog(32'h0001_8020, DEV0, 32'h0, 32'h0, 12'h002, 2'h2);
        span(ST_START_DLY, 12, -1);
        // keyed offset on a slow ramp
        prog(32'h0, 32'h0210_0028, 32'h0288_0038, 32'h0, 12'h014, 2'h0);
        base();
        hop(BASE + 37'h14, 0);
        @(posedge clk_sys);
        freqKeyPin <= 1'b1;
        hop(BASE + 37'h22, 0);
        @(posedge clk_sys);
        freqKeyPin <= 1'b0;
        hop(BASE + 37'h14, 0);
        wr(4'h0, F0);
        waitst(ST_IDLE);
        repeat (2) @(negedge clk_sys);
        cmpv(divValue, BASE);
        cmpv(37'(rampActive), 37'h0);
        end_sim();
    end
endmodule : fmrs_ramp_sequencer_tb
`default_nettype wire
